// file: logic/spm_port.sv
// serial port mode and pin control: registers, transfer engine, pin muxing
// assumes pads resolve each pin from out/oe and that wait_mode_i is synchronous
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module spm_port (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // system
   input wire logic wait_mode_i,
   output logic irq_o,
   // serial pins
   input wire spm_pkg::spm_pin_in_t pins_i,
   output spm_pkg::spm_pin_out_t pins_o,
   output logic ss_gpio_o
);

   ////////////////////////////////////////////////////////////////////////
   // state and decoded controls
   spm_pkg::spm_state_t st;
   spm_pkg::spm_state_t next_st;

   logic en, master_select, clock_polarity_select, clock_phase_select, select_output_enable, low_bit_first_enable;
   logic modf, swoe, swai, swsel;
   logic run, sck_lvl, ss_lvl, rx_pin, sck_edge, ss_sel, modf_evt;
   logic req, wr, rd, wr0, tx_bit, mxfer, active;

   // control fields
   assign en = st.ctrl1[spm_pkg::C1_EN];
   assign master_select = st.ctrl1[spm_pkg::C1_MASTER_SELECT];
   assign clock_polarity_select = st.ctrl1[spm_pkg::C1_CLOCK_POLARITY_SELECT];
   assign clock_phase_select = st.ctrl1[spm_pkg::C1_CLOCK_PHASE_SELECT];
   assign select_output_enable = st.ctrl1[spm_pkg::C1_SELECT_OUTPUT_ENABLE];
   assign low_bit_first_enable = st.ctrl1[spm_pkg::C1_LOW_BIT_FIRST_ENABLE];
   assign modf = st.ctrl2[spm_pkg::C2_MODF];
   assign swoe = st.ctrl2[spm_pkg::C2_SWOE];
   assign swai = st.ctrl2[spm_pkg::C2_SWAI];
   assign swsel = st.ctrl2[spm_pkg::C2_SWSEL];

   // clocks stop in wait only when asked to
   assign run = !(swai && wait_mode_i);

   // filtered pin levels
   assign sck_lvl = st.lvl[spm_pkg::PI_SCK];
   assign ss_lvl = st.lvl[spm_pkg::PI_SS];
   assign sck_edge = sck_lvl != st.sck_prev;

   // received data pin by role and wiring
   always_comb begin
      if (master_select) begin
         rx_pin = swsel ? st.lvl[spm_pkg::PI_MOSI] : st.lvl[spm_pkg::PI_MISO];
      end else begin
         rx_pin = swsel ? st.lvl[spm_pkg::PI_MISO] : st.lvl[spm_pkg::PI_MOSI];
      end
   end

   // selection and fault detection
   assign ss_sel = en && !master_select && !ss_lvl;
   assign modf_evt = en && master_select && modf && !select_output_enable && !ss_lvl;

   // bus request decode
   assign req = wb_cyc_i && wb_stb_i && !st.ack;
   assign wr = req && wb_we_i;
   assign rd = req && !wb_we_i;
   assign wr0 = wr && wb_sel_i[0];

   // outgoing bit and clock phase
   assign tx_bit = low_bit_first_enable ? st.shreg[0] : st.shreg[7];
   assign mxfer = st.mode == spm_pkg::SPM_MXFER;
   assign active = st.h[0] ^ clock_phase_select;

   ////////////////////////////////////////////////////////////////////////
   // shift one bit in at the end that was not sent first
   function automatic logic [7:0] spm_shift(input logic [7:0] v, input logic b,
                                           input logic lsb);
      if (lsb) begin
         return {b, v[7:1]};
      end else begin
         return {v[6:0], b};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic ev_done;
      logic [4:0] nh;
      ev_done = 1'b0;
      nh = st.h + 5'h01;
      next_st = st;

      // three-stage pin synchroniser, level moves when stages two and three agree
      next_st.s1 = pins_i;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.lvl = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.lvl);
      next_st.sck_prev = sck_lvl;

      // bus answer one cycle after the request
      next_st.ack = req;

      // register writes
      if (wr0) begin
         unique case (wb_adr_i)
            spm_pkg::ADR_CTRL1: next_st.ctrl1 = wb_dat_i[7:0] & spm_pkg::C1_IMPL;
            spm_pkg::ADR_CTRL2: next_st.ctrl2 = wb_dat_i[7:0] & spm_pkg::C2_IMPL;
            spm_pkg::ADR_DATA: next_st.txbuf = wb_dat_i[7:0];
            spm_pkg::ADR_MASK: next_st.mask = wb_dat_i[1:0];
            default: ;
         endcase
      end

      // register reads, unmapped reads give zero
      if (rd) begin
         unique case (wb_adr_i)
            spm_pkg::ADR_CTRL1: next_st.rdat = st.ctrl1;
            spm_pkg::ADR_CTRL2: next_st.rdat = st.ctrl2 & spm_pkg::C2_IMPL;
            spm_pkg::ADR_DATA: next_st.rdat = st.rxbuf;
            spm_pkg::ADR_STAT: next_st.rdat = {st.mode != spm_pkg::SPM_IDLE, 5'h00, st.status};
            spm_pkg::ADR_MASK: next_st.rdat = {6'h00, st.mask};
            default: next_st.rdat = 8'h00;
         endcase
      end

      // transfer engine, frozen while the port clocks are stopped
      unique case (st.mode)
         spm_pkg::SPM_IDLE: begin
            next_st.h = 5'h00;
            next_st.div = 3'h0;
            if (run) begin
               if (en && master_select && wr0 && wb_adr_i == spm_pkg::ADR_DATA) begin
                  next_st.shreg = wb_dat_i[7:0];
                  next_st.mode = spm_pkg::SPM_MXFER;
               end else if (ss_sel) begin
                  next_st.shreg = st.txbuf;
                  // late phase: first edge only presents the first bit
                  next_st.h = clock_phase_select ? spm_pkg::H_SLV_LATE : 5'h00;
                  next_st.mode = spm_pkg::SPM_SXFER;
               end
            end
         end
         spm_pkg::SPM_MXFER: begin
            if (run) begin
               if (st.div == spm_pkg::HALF_LAST) begin
                  next_st.div = 3'h0;
                  next_st.h = nh;
                  // input read at the close of each bit: the pin synchroniser lags
                  // the far side by a whole half bit of four bus clocks, so the leading edge is too soon
                  if (st.h == spm_pkg::H_LAST) begin
                     next_st.rxbuf = spm_shift(st.shreg, rx_pin, low_bit_first_enable);
                     next_st.mode = spm_pkg::SPM_IDLE;
                     ev_done = 1'b1;
                  end else if (!nh[0]) begin
                     next_st.shreg = spm_shift(st.shreg, rx_pin, low_bit_first_enable);
                  end
               end else begin
                  next_st.div = st.div + 3'h1;
               end
            end
         end
         spm_pkg::SPM_SXFER: begin
            if (!ss_sel) begin
               next_st.mode = spm_pkg::SPM_IDLE;
            end else if (run && sck_edge) begin
               next_st.h = nh;
               if (nh == spm_pkg::H_LAST) begin
                  next_st.rxbuf = spm_shift(st.shreg, rx_pin, low_bit_first_enable);
                  next_st.mode = spm_pkg::SPM_SHOLD;
                  ev_done = 1'b1;
               end else if (nh[0]) begin
                  next_st.samp = rx_pin;
               end else if (nh != 5'h00) begin
                  next_st.shreg = spm_shift(st.shreg, st.samp, low_bit_first_enable);
               end
            end
         end
         spm_pkg::SPM_SHOLD: begin
            // wait for deselect before the next slave byte
            if (!ss_sel) begin
               next_st.mode = spm_pkg::SPM_IDLE;
            end
         end
      endcase

      // a mode fault drops the port back to slave and ends the transfer
      if (modf_evt) begin
         next_st.ctrl1[spm_pkg::C1_MASTER_SELECT] = 1'b0;
         next_st.mode = spm_pkg::SPM_IDLE;
      end

      // disabled port stays idle
      if (!en) begin
         next_st.mode = spm_pkg::SPM_IDLE;
      end

      // sticky events: a status read clears, a new event in the same cycle wins
      if (rd && wb_adr_i == spm_pkg::ADR_STAT) begin
         next_st.status = 2'h0;
      end
      if (ev_done) begin
         next_st.status[spm_pkg::ST_DONE] = 1'b1;
      end
      if (modf_evt) begin
         next_st.status[spm_pkg::ST_MODF] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
         st.ctrl1 <= spm_pkg::CTRL1_RST;
         st.ctrl2 <= spm_pkg::CTRL2_RST;
         st.mask <= spm_pkg::MASK_RST;
         st.mode <= spm_pkg::SPM_IDLE;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drive
   always_comb begin
      pins_o = '0;
      // master drives the clock, idle level set by polarity
      pins_o.sck_oe = en && master_select;
      pins_o.sck = clock_polarity_select ^ (mxfer && active);
      // master data pin: always out on separate pins, by enable when shared
      pins_o.mosi = tx_bit;
      pins_o.mosi_oe = en && master_select && (!swsel || swoe);
      // slave data pin: driven while selected, by enable when shared
      pins_o.miso = tx_bit;
      pins_o.miso_oe = en && !master_select && !ss_lvl && (!swsel || swoe);
      // automatic select output, low during a master transfer
      pins_o.ss = !mxfer;
      pins_o.ss_oe = en && master_select && modf && select_output_enable;
   end

   // select pin handed to general-purpose control
   assign ss_gpio_o = master_select && !modf;

   // bus and interrupt outputs
   assign wb_dat_o = {24'h000000, st.rdat};
   assign wb_ack_o = st.ack;
   assign irq_o = |(st.status & st.mask);

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_slave_no_clock: assert property (
      !master_select |-> !pins_o.sck_oe && !pins_o.ss_oe)
      else $error("slave drives clock or select");

   chk_clock_idle: assert property (
      (en && master_select && st.mode == spm_pkg::SPM_IDLE) |-> pins_o.sck == clock_polarity_select)
      else $error("serial clock not at idle level");

   chk_first_edge: assert property (
      (st.mode == spm_pkg::SPM_IDLE && next_st.mode == spm_pkg::SPM_MXFER)
      |=> pins_o.sck == (clock_polarity_select ^ clock_phase_select) ##[1:8] pins_o.sck == !(clock_polarity_select ^ clock_phase_select))
      else $error("first clock edge at wrong point");

   chk_first_bit: assert property (
      (st.mode == spm_pkg::SPM_IDLE && next_st.mode == spm_pkg::SPM_MXFER && !modf_evt)
      |=> pins_o.mosi == (low_bit_first_enable ? $past(wb_dat_i[0]) : $past(wb_dat_i[7])))
      else $error("wrong first bit order");

   chk_ss_released: assert property (
      (master_select && !modf) |-> ss_gpio_o && !pins_o.ss_oe)
      else $error("select pin not released");

   chk_mode_fault: assert property (
      modf_evt |=> st.status[spm_pkg::ST_MODF] && !master_select && st.mode == spm_pkg::SPM_IDLE)
      else $error("mode fault not taken");

   chk_ss_auto: assert property (
      (en && master_select && modf && select_output_enable && mxfer) |-> pins_o.ss_oe && !pins_o.ss)
      else $error("select not driven low in transfer");

   chk_slave_select: assert property (
      !master_select |-> !ss_gpio_o && !pins_o.ss_oe)
      else $error("slave select pin misused");

   chk_ctrl2_zero: assert property (
      (wb_ack_o && !wb_we_i && wb_adr_i == spm_pkg::ADR_CTRL2)
      |-> wb_dat_o[7:5] == 3'h0 && wb_dat_o[2] == 1'b0)
      else $error("unimplemented option bits read nonzero");

   chk_separate_pins: assert property (
      (en && master_select && !swsel) |-> pins_o.mosi_oe && !pins_o.miso_oe)
      else $error("separate pin wiring wrong");

   chk_shared_pin_oe: assert property (
      (en && swsel) |-> !(pins_o.mosi_oe || pins_o.miso_oe) || swoe)
      else $error("shared pin driven with enable low");

   chk_wait_freeze: assert property (
      (swai && wait_mode_i && mxfer) |=> $stable(st.h) && $stable(st.div))
      else $error("transfer advanced in wait");

   chk_fault_input: assert property (
      (en && master_select && modf && !select_output_enable) |-> !pins_o.ss_oe && !ss_gpio_o)
      else $error("fault input driven or released");

   chk_slave_quiet: assert property (
      (en && !master_select && ss_lvl) |-> !pins_o.miso_oe ##1 st.mode != spm_pkg::SPM_SXFER)
      else $error("deselected slave still active");

   chk_done_sticky: assert property (
      (st.status[spm_pkg::ST_DONE] && !(rd && wb_adr_i == spm_pkg::ADR_STAT))
      |=> st.status[spm_pkg::ST_DONE])
      else $error("done flag lost before read");

endmodule

`default_nettype wire

// file: logic/spm_pkg.sv
// serial port mode and pin control: shared constants and types
// assumes a 20 MHz bus clock and a classic wishbone register port
package spm_pkg;

   ////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_NS = 50;
   localparam int SCK_HALF_NS = 200;
   localparam int HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0] HALF_LAST = 3'(HALF_CYC - 1);

   ////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] ADR_CTRL1 = 8'h00;
   localparam logic [7:0] ADR_CTRL2 = 8'h04;
   localparam logic [7:0] ADR_DATA = 8'h08;
   localparam logic [7:0] ADR_STAT = 8'h0c;
   localparam logic [7:0] ADR_MASK = 8'h10;

   // first control register fields
   localparam int C1_EN = 6;
   localparam int C1_MASTER_SELECT = 4;
   localparam int C1_CLOCK_POLARITY_SELECT = 3;
   localparam int C1_CLOCK_PHASE_SELECT = 2;
   localparam int C1_SELECT_OUTPUT_ENABLE = 1;
   localparam int C1_LOW_BIT_FIRST_ENABLE = 0;
   localparam logic [7:0] C1_IMPL = 8'h5f;
   localparam logic [7:0] CTRL1_RST = 8'h04;

   // option control register fields
   localparam int C2_MODF = 4;
   localparam int C2_SWOE = 3;
   localparam int C2_SWAI = 1;
   localparam int C2_SWSEL = 0;
   localparam logic [7:0] C2_IMPL = 8'h1b;
   localparam logic [7:0] CTRL2_RST = 8'h00;

   // status and mask fields
   localparam int ST_DONE = 0;
   localparam int ST_MODF = 1;
   localparam int ST_BUSY = 7;
   localparam logic [1:0] MASK_RST = 2'h0;

   // half-period index of a transfer
   localparam logic [4:0] H_LAST = 5'h0f;
   localparam logic [4:0] H_SLV_LATE = 5'h1f;

   // synchroniser bit positions
   localparam int PI_SCK = 3;
   localparam int PI_MOSI = 2;
   localparam int PI_MISO = 1;
   localparam int PI_SS = 0;

   ////////////////////////////////////////////////////////////////////////
   // types
   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ss;
   } spm_pin_in_t;

   typedef struct packed {
      logic sck;
      logic sck_oe;
      logic mosi;
      logic mosi_oe;
      logic miso;
      logic miso_oe;
      logic ss;
      logic ss_oe;
   } spm_pin_out_t;

   typedef enum logic [1:0] {SPM_IDLE, SPM_MXFER, SPM_SXFER, SPM_SHOLD} spm_mode_t;

   typedef struct packed {
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [1:0] mask;
      logic [1:0] status;
      logic [7:0] txbuf;
      logic [7:0] rxbuf;
      logic [7:0] shreg;
      logic samp;
      spm_mode_t mode;
      logic [4:0] h;
      logic [2:0] div;
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] lvl;
      logic sck_prev;
      logic ack;
      logic [7:0] rdat;
   } spm_state_t;

endpackage

// file: sim/spm_peer.sv
// external serial slave that faces the port when it runs as a master
// assumes the bench resolves every shared pin and hands over the frame format
`timescale 1ns/100ps
`default_nettype none

module spm_peer (
   // resolved pins
   input wire logic sck_i,
   input wire logic ss_n_i,
   input wire logic mosi_i,
   // frame format and byte to send
   input wire logic clock_polarity_select_i,
   input wire logic clock_phase_select_i,
   input wire logic lsb_i,
   input wire logic [7:0] tx_i,
   // results
   output logic miso_o,
   output logic [7:0] rx_o
);
   int n;
   logic lead;

   ////////////////////////////////////////////////////////////////////////
   // bit position of the n-th bit on the wire
   function automatic int pos(input int k);
      pos = lsb_i ? k : 7 - k;
   endfunction

   // power-up state
   initial begin
      miso_o = 1'b0;
      rx_o = 8'h00;
      n = 0;
   end

   // select restarts the frame; phase 0 shows the first bit at once, and
   // phase 1 too when the first clock edge came in the same instant
   always @(negedge ss_n_i) begin
      n = 0;
      if (!clock_phase_select_i || sck_i != clock_polarity_select_i) miso_o = tx_i[pos(0)];
   end

   // released line no longer holds its last level
   always @(posedge ss_n_i) miso_o = ~miso_o;

   // leading edge leaves the idle level; phase picks sample or shift
   always @(sck_i) begin
      if (ss_n_i === 1'b0) begin
         lead = (sck_i != clock_polarity_select_i);
         if (lead != clock_phase_select_i) begin
            if (n < 8) rx_o[pos(n)] = mosi_i;
            if (clock_phase_select_i) n = n + 1;
         end else begin
            if (!clock_phase_select_i) n = n + 1;
            if (n < 8) miso_o = tx_i[pos(n)];
         end
      end
   end
endmodule
`default_nettype wire

// file: sim/test_spm_port.sv
// self-checking bench of the serial port mode and pin control block
// assumes spm_pkg, spm_port and spm_peer are compiled before it
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
   $display("ERROR at %0t: got %h want %h", $time, (g), (e)); end end

module test_spm_port;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, wait_mode = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat_w = 32'h0, dat_r;
   logic ack, irq_o, ss_gpio_o, b_sck = 1'b0, b_mosi = 1'b0, b_ss = 1'b1;
   logic p_clock_polarity_select = 1'b0, p_clock_phase_select = 1'b0, p_lsb = 1'b0, p_miso;
   logic [7:0] p_tx = 8'h00, p_rx, got;
   spm_pkg::spm_pin_out_t pins_o;
   wire logic sck_w, mosi_w, miso_w, ss_w;
   wire spm_pkg::spm_pin_in_t pin_in;
   int err_count = 0, n_compared = 0, n_edge = 0, e0;
   logic [2:0] kb;

   ////////////////////////////////////////////////////////////////////////
   // clock, pin resolution and serial clock edge count, cleared as a frame starts
   always #25 clk_i = ~clk_i;
   assign sck_w = pins_o.sck_oe ? pins_o.sck : b_sck;
   assign mosi_w = pins_o.mosi_oe ? pins_o.mosi : b_mosi;
   assign miso_w = pins_o.miso_oe ? pins_o.miso : p_miso;
   assign ss_w = pins_o.ss_oe ? pins_o.ss : b_ss;
   assign pin_in = {sck_w, mosi_w, miso_w, ss_w};
   always @(sck_w) n_edge++;

   spm_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
      .wb_ack_o(ack), .wait_mode_i(wait_mode), .irq_o(irq_o), .pins_i(pin_in),
      .pins_o(pins_o), .ss_gpio_o(ss_gpio_o));
   spm_peer u_peer (.sck_i(sck_w), .ss_n_i(ss_w), .mosi_i(mosi_w), .clock_polarity_select_i(p_clock_polarity_select),
      .clock_phase_select_i(p_clock_phase_select), .lsb_i(p_lsb), .tx_i(p_tx), .miso_o(p_miso), .rx_o(p_rx));

   ////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // one classic wishbone cycle, held until ack is sampled
   task automatic wb_io(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
      int i;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= {24'h000000, d};
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (ack === 1'b1) break;
      end
      if (i == 20) begin
         err_count++;
         $display("ERROR at %0t: bus timeout", $time);
         stop_test();
      end
      q = dat_r[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb_io(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      wb_io(1'b0, a, 8'h00, q);
      `CHK(q, e)
   endtask

   // bounded wait for the interrupt line
   task automatic wait_irq();
      int i;
      for (i = 0; i < 400; i++) begin
         if (irq_o === 1'b1) break;
         @(posedge clk_i);
      end
      if (i == 400) begin
         err_count++;
         $display("ERROR at %0t: no interrupt", $time);
         stop_test();
      end
   endtask

   // master transfer: start, then check both bytes and the edge count
   task automatic x_start(input logic [7:0] d, input logic [7:0] t);
      p_tx <= t;
      n_edge = 0;
      wr(spm_pkg::ADR_DATA, d);
   endtask
   task automatic x_end(input logic [7:0] d, input logic [7:0] t);
      wait_irq();
      `CHK(n_edge, 16)
      `CHK(p_rx, d)
      rd_chk(spm_pkg::ADR_STAT, 8'h01);
      rd_chk(spm_pkg::ADR_DATA, t);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(spm_pkg::ADR_CTRL1, 8'h04);
      `CHK({pins_o.sck_oe, pins_o.mosi_oe, pins_o.miso_oe, pins_o.ss_oe}, 4'h0)
      wr(spm_pkg::ADR_CTRL2, 8'hff);
      rd_chk(spm_pkg::ADR_CTRL2, 8'h1b);
      rd_chk(8'h20, 8'h00);
      $display("test registers done");
      // select pin use for every mode, fault enable and output enable
      for (int k = 0; k < 8; k++) begin
         kb = k[2:0];
         wr(spm_pkg::ADR_CTRL2, {3'h0, kb[1], 4'h0});
         wr(spm_pkg::ADR_CTRL1, {3'h2, kb[2], 2'h0, kb[0], 1'b0});
         `CHK(pins_o.sck_oe, kb[2])
         `CHK(ss_gpio_o, kb[2] & ~kb[1])
         `CHK(pins_o.ss_oe, &kb)
         if (kb[2] & ~(kb[1] & kb[0])) begin
            b_ss <= 1'b0;
            repeat (10) @(posedge clk_i);
            b_ss <= 1'b1;
            repeat (8) @(posedge clk_i);
            rd_chk(spm_pkg::ADR_STAT, {6'h0, kb[1], 1'b0});
         end
      end
      $display("test select pin done");
      // every polarity, phase and order with the automatic select
      wr(spm_pkg::ADR_MASK, 8'h01);
      wr(spm_pkg::ADR_CTRL2, 8'h10);
      for (int k = 0; k < 8; k++) begin
         kb = k[2:0];
         {p_clock_polarity_select, p_clock_phase_select, p_lsb} <= kb;
         wr(spm_pkg::ADR_CTRL1, {3'h2, 1'b1, kb[2:1], 1'b1, kb[0]});
         `CHK(pins_o.sck, kb[2])
         x_start(8'h96 ^ {5'h0, kb}, 8'h3c ^ {kb, 5'h0});
         x_end(8'h96 ^ {5'h0, kb}, 8'h3c ^ {kb, 5'h0});
      end
      // a masked event raises no interrupt until the mask opens
      wr(spm_pkg::ADR_MASK, 8'h00);
      x_start(8'h81, 8'h7e);
      rd_chk(spm_pkg::ADR_STAT, 8'h80);
      repeat (80) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      wr(spm_pkg::ADR_MASK, 8'h01);
      x_end(8'h81, 8'h7e);
      repeat (2) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      $display("test transfers done");
      // stop in wait freezes a frame, running on in wait does not
      wr(spm_pkg::ADR_CTRL2, 8'h12);
      x_start(8'hc3, 8'h18);
      repeat (8) @(posedge clk_i);
      wait_mode <= 1'b1;
      @(posedge clk_i);
      e0 = n_edge;
      repeat (100) @(posedge clk_i);
      `CHK(n_edge, e0)
      wait_mode <= 1'b0;
      x_end(8'hc3, 8'h18);
      wr(spm_pkg::ADR_CTRL2, 8'h10);
      wait_mode <= 1'b1;
      x_start(8'h24, 8'he7);
      x_end(8'h24, 8'he7);
      wait_mode <= 1'b0;
      $display("test wait mode done");
      // data drivers for split and single-wire master
      for (int k = 0; k < 4; k++) begin
         kb = k[2:0];
         wr(spm_pkg::ADR_CTRL2, {3'h0, 1'b1, kb[1], 2'h0, kb[0]});
         `CHK(pins_o.mosi_oe, ~kb[0] | kb[1])
         `CHK(pins_o.miso_oe, 1'b0)
      end
      $display("test single wire done");
      // slave frame: enables have no say over the select input
      wr(spm_pkg::ADR_CTRL2, 8'h10);
      wr(spm_pkg::ADR_CTRL1, 8'h42);
      {p_clock_polarity_select, p_clock_phase_select, p_lsb} <= 3'h0;
      wr(spm_pkg::ADR_DATA, 8'ha5);
      b_ss <= 1'b0;
      repeat (8) @(posedge clk_i);
      `CHK(pins_o.miso_oe, 1'b1)
      `CHK(pins_o.ss_oe, 1'b0)
      for (int i = 7; i >= 0; i--) begin
         b_mosi <= ~i[0];
         repeat (4) @(posedge clk_i);
         b_sck <= 1'b1;
         repeat (4) @(posedge clk_i);
         got[i] = miso_w;
         b_sck <= 1'b0;
      end
      repeat (8) @(posedge clk_i);
      b_ss <= 1'b1;
      wait_irq();
      `CHK(got, 8'ha5)
      rd_chk(spm_pkg::ADR_DATA, 8'h55);
      $display("test slave done");
      stop_test();
   end
endmodule
`default_nettype wire
